/* File: design/wsc_consts.svh */
// Offsets, field positions, reset, restart and fail-safe values of the wake source control bank
// How it works
// - Bit 5 selects low or high peak
// - Peak bit writable only in init/normal
// - Stop-mode peak write: no fault, no interrupt
// - Fail-safe entry forces wake register values
// - Reserved bit positions always read zero
// - Bits 7/6 enable second/first timer wake
// - Bit 2 watchdog stop-off, device-updatable
// - Bit 7 widens interrupt to all status
// - Measure bit ignores wake inputs one, two
// - Measurement runs in normal; host ignores levels
// - Bits 2:0 enable wake inputs three..one
// - Bus control two restart keeps bit 5
// - Internal wake restart keeps bits 7:6
// - External wake resets 0x07, restart keeps all
// - Three 2-bit pull fields, restart keeps
// - Pull codes: none, down, up, auto
`ifndef WSC_CONSTS_SVH
`define WSC_CONSTS_SVH

////////////////////////////////////////////////////////////////////////////////
// Register offsets (7-bit register address)
`define WSC_OFF_BUS_CTRL2     7'h05
`define WSC_OFF_INT_WAKE      7'h06
`define WSC_OFF_EXT_WAKE      7'h07
`define WSC_OFF_PULL_CFG      7'h08

////////////////////////////////////////////////////////////////////////////////
// Field positions
`define WSC_BC2_PEAK_BIT      5
`define WSC_IWC_T2_BIT        7
`define WSC_IWC_T1_BIT        6
`define WSC_IWC_WD_BIT        2
`define WSC_EWC_GLOBAL_BIT    7
`define WSC_EWC_MEAS_BIT      5
`define WSC_NUM_WAKE          3

////////////////////////////////////////////////////////////////////////////////
// Implemented bits, power-on / soft reset values, restart keep masks
`define WSC_BC2_MASK          8'h20
`define WSC_IWC_MASK          8'hc4
`define WSC_EWC_MASK          8'ha7
`define WSC_PULL_MASK         8'h3f
`define WSC_BC2_RST           8'h00
`define WSC_IWC_RST           8'h00
`define WSC_EWC_RST           8'h07
`define WSC_PULL_RST          8'h00
`define WSC_BC2_KEEP          8'h20
`define WSC_IWC_KEEP          8'hc0
`define WSC_EWC_KEEP          8'ha7
`define WSC_PULL_KEEP         8'h3f

////////////////////////////////////////////////////////////////////////////////
// Fail-safe forcing: kept bits, then bits forced to one
`define WSC_BC2_FS            8'h00
`define WSC_EWC_FS_KEEP       8'ha0
`define WSC_EWC_FS_SET        8'h07

////////////////////////////////////////////////////////////////////////////////
// Pull field codes
`define WSC_PULL_NONE         2'h0
`define WSC_PULL_DOWN         2'h1
`define WSC_PULL_UP           2'h2
`define WSC_PULL_AUTO         2'h3

`endif

/* File: design/wsc_pkg.sv */
// Types shared by the wake source control bank
`include "wsc_consts.svh"
package wsc_pkg;

  // Operating mode reported by the device mode controller
  typedef enum logic [1:0] {
    WSC_MODE_INIT,
    WSC_MODE_NORMAL,
    WSC_MODE_STOP,
    WSC_MODE_OTHER
  } wsc_mode_e;

  // Register bank state
  typedef struct packed {
    logic [7:0] bc2;          // Bus control two
    logic [7:0] iwc;          // Internal wake control
    logic [7:0] ewc;          // External wake control
    logic [7:0] pull;         // Wake input pull config
    logic [7:0] rdata;        // Read answer
    logic       rvalid;       // Read answer strobe
    logic       int_req;      // Interrupt request
    logic       wake_req;     // Wake request from pins
  } wsc_state_s;

  // Wake pin front end state
  typedef struct packed {
    logic [`WSC_NUM_WAKE-1:0] s1;        // Sync stage one
    logic [`WSC_NUM_WAKE-1:0] s2;        // Sync stage two
    logic [`WSC_NUM_WAKE-1:0] s3;        // Sync stage three
    logic [`WSC_NUM_WAKE-1:0] level;     // Accepted level
    logic [`WSC_NUM_WAKE-1:0] pull_up;   // Pull-up enables
    logic [`WSC_NUM_WAKE-1:0] pull_down; // Pull-down enables
  } wsc_pins_s;

endpackage

/* File: design/wsc_wake_pins.sv */
// Wake input synchroniser and pull resistor control
`include "wsc_consts.svh"
module wsc_wake_pins (
  // Clock and reset
  input  wire logic                      i_mclk,
  input  wire logic                      i_reset_n,
  // Pins and configuration
  input  wire logic [`WSC_NUM_WAKE-1:0]   i_pin,
  input  wire logic [2*`WSC_NUM_WAKE-1:0] i_pull_cfg,
  // Results
  output logic      [`WSC_NUM_WAKE-1:0]   o_level,
  output logic      [`WSC_NUM_WAKE-1:0]   o_pull_up,
  output logic      [`WSC_NUM_WAKE-1:0]   o_pull_down
);
  import wsc_pkg::*;

  wsc_pins_s                st_reg;   // Registered state
  wsc_pins_s                st_next;  // Next state
  logic [`WSC_NUM_WAKE-1:0] up_d;     // Decoded pull-up
  logic [`WSC_NUM_WAKE-1:0] dn_d;     // Decoded pull-down

  ////////////////////////////////////////////////////////////////////////////////
  // Per-input pull decode; auto follows the settled level so the pin is held, not fought
  genvar g;
  generate
    for (g = 0; g < `WSC_NUM_WAKE; g++) begin : g_pull
      logic [1:0] cfg;
      assign cfg     = i_pull_cfg[2*g +: 2];
      assign up_d[g] = (cfg == `WSC_PULL_UP) ||
                       ((cfg == `WSC_PULL_AUTO) && st_reg.level[g]);
      assign dn_d[g] = (cfg == `WSC_PULL_DOWN) ||
                       ((cfg == `WSC_PULL_AUTO) && !st_reg.level[g]);
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////////
  // Next state: three-stage sync, accept a level once stages two and three agree
  always_comb begin
    st_next           = st_reg;
    st_next.s1        = i_pin;
    st_next.s2        = st_reg.s1;
    st_next.s3        = st_reg.s2;
    // Only bits where the late stages agree move; a lone glitch never lands
    st_next.level     = (st_reg.level & (st_reg.s2 ^ st_reg.s3)) |
                        (st_reg.s2 & ~(st_reg.s2 ^ st_reg.s3));
    st_next.pull_up   = up_d;
    st_next.pull_down = dn_d;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign o_level     = st_reg.level;
  assign o_pull_up   = st_reg.pull_up;
  assign o_pull_down = st_reg.pull_down;

  ////////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_reset_n);

  sync_agree_a: assert property (((o_level ^ $past(o_level)) &
      ($past(st_reg.s2) ^ $past(st_reg.s3))) == '0)
    else $error("wake level moved while sync stages disagreed");
  pull_none_a: assert property ((i_pull_cfg[1:0] == `WSC_PULL_NONE) |=>
      !o_pull_up[0] && !o_pull_down[0])
    else $error("pull active with no-pull code");
  pull_up_a: assert property ((i_pull_cfg[3:2] == `WSC_PULL_UP) |=>
      o_pull_up[1] && !o_pull_down[1])
    else $error("pull-up code not applied");
  pull_auto_a: assert property ((i_pull_cfg[5:4] == `WSC_PULL_AUTO) |=>
      (o_pull_up[2] != o_pull_down[2]))
    else $error("auto pull drives neither or both");

endmodule

/* File: design/wsc_regs.sv */
// Wake source control register bank: peak threshold, timer and pin wake control, pulls
`include "wsc_consts.svh"
module wsc_regs (
  // Clock and reset
  input  wire logic                     i_mclk,
  input  wire logic                     i_reset_n,
  // Register access from the serial control frame decoder
  input  wire logic                     i_wr_stb,
  input  wire logic                     i_rd_stb,
  input  wire logic [6:0]               i_addr,
  input  wire logic [7:0]               i_wdata,
  output logic      [7:0]               o_rdata,
  output logic                          o_rvalid,
  // Device mode and mode events
  input  wsc_pkg::wsc_mode_e            i_mode,
  input  wire logic                     i_soft_reset,
  input  wire logic                     i_restart,
  input  wire logic                     i_failsafe_entry,
  // Device-side update of the watchdog stop-off bit
  input  wire logic                     i_wd_off1_hw_stb,
  input  wire logic                     i_wd_off1_hw_val,
  // Interrupt sources
  input  wire logic                     i_wake_event,
  input  wire logic                     i_status_event,
  output logic                          o_int_req,
  // Wake pins
  input  wire logic [`WSC_NUM_WAKE-1:0] i_wake_pin,
  output logic      [`WSC_NUM_WAKE-1:0] o_wake_level,
  output logic      [`WSC_NUM_WAKE-1:0] o_pull_up,
  output logic      [`WSC_NUM_WAKE-1:0] o_pull_down,
  output logic                          o_wake_req,
  // Configuration outputs
  output logic                          o_supply_peak_threshold_sel,
  output logic                          o_first_timer_wake_en,
  output logic                          o_second_timer_wake_en,
  output logic                          o_stop_watchdog_off_bit1,
  output logic                          o_int_global,
  output logic                          o_wake_measure_sel,
  output logic                          o_wake_measure_active,
  output logic      [`WSC_NUM_WAKE-1:0] o_wake_in_en
);
  import wsc_pkg::*;

  wsc_state_s               st_reg;     // Registered state
  wsc_state_s               st_next;    // Next state
  logic [`WSC_NUM_WAKE-1:0] wake_level; // Settled pin levels
  logic [`WSC_NUM_WAKE-1:0] en_eff;     // Effective wake enables

  ////////////////////////////////////////////////////////////////////////////////
  // Effective wake enables: measurement use takes inputs one and two out of wake
  always_comb begin
    en_eff    = st_reg.ewc[2:0];
    en_eff[2] = st_reg.ewc[2];
    if (st_reg.ewc[`WSC_EWC_MEAS_BIT]) begin
      en_eff[1:0] = 2'h0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Next state; later steps override earlier ones:
  // host write, device update, restart, fail-safe, soft reset
  always_comb begin
    st_next        = st_reg;
    st_next.rvalid = 1'b0;
    st_next.rdata  = 8'h00;

    // Read answer; stored bits are already masked, so reserved reads zero
    if (i_rd_stb) begin
      st_next.rvalid = 1'b1;
      case (i_addr)
        `WSC_OFF_BUS_CTRL2: begin
          st_next.rdata = st_reg.bc2 & `WSC_BC2_MASK;
        end
        `WSC_OFF_INT_WAKE: begin
          st_next.rdata = st_reg.iwc & `WSC_IWC_MASK;
        end
        `WSC_OFF_EXT_WAKE: begin
          st_next.rdata = st_reg.ewc & `WSC_EWC_MASK;
        end
        `WSC_OFF_PULL_CFG: begin
          st_next.rdata = st_reg.pull & `WSC_PULL_MASK;
        end
        default: begin
          // Other addresses belong to other banks and read zero here
          st_next.rdata = 8'h00;
        end
      endcase
    end

    // Host write; reserved positions are dropped before storing
    if (i_wr_stb) begin
      case (i_addr)
        `WSC_OFF_BUS_CTRL2: begin
          if ((i_mode == WSC_MODE_INIT) || (i_mode == WSC_MODE_NORMAL)) begin
            st_next.bc2 = i_wdata & `WSC_BC2_MASK;
          end else begin
            // Stop and other modes: silently dropped, no fault and no interrupt source
            st_next.bc2 = st_reg.bc2;
          end
        end
        `WSC_OFF_INT_WAKE: begin
          st_next.iwc = i_wdata & `WSC_IWC_MASK;
        end
        `WSC_OFF_EXT_WAKE: begin
          st_next.ewc = i_wdata & `WSC_EWC_MASK;
        end
        `WSC_OFF_PULL_CFG: begin
          st_next.pull = i_wdata & `WSC_PULL_MASK;
        end
        default: begin
          st_next.bc2 = st_reg.bc2;
        end
      endcase
    end

    // Device update wins over a host write in the same cycle
    if (i_wd_off1_hw_stb) begin
      st_next.iwc[`WSC_IWC_WD_BIT] = i_wd_off1_hw_val;
    end

    // Restart: keep only the bits that survive it
    if (i_restart) begin
      st_next.bc2  = st_next.bc2 & `WSC_BC2_KEEP;
      st_next.iwc  = st_next.iwc & `WSC_IWC_KEEP;
      st_next.ewc  = st_next.ewc & `WSC_EWC_KEEP;
      st_next.pull = st_next.pull & `WSC_PULL_KEEP;
    end

    // Fail-safe entry forces the pin wake enables on but keeps the measure bit, so measuring still mutes inputs one and two
    if (i_failsafe_entry) begin
      st_next.bc2 = `WSC_BC2_FS;
      st_next.ewc = (st_next.ewc & `WSC_EWC_FS_KEEP) | `WSC_EWC_FS_SET;
    end

    // Soft reset returns the power-on values
    if (i_soft_reset) begin
      st_next.bc2  = `WSC_BC2_RST;
      st_next.iwc  = `WSC_IWC_RST;
      st_next.ewc  = `WSC_EWC_RST;
      st_next.pull = `WSC_PULL_RST;
    end

    // Interrupt scope: wake events always, other status only when global
    st_next.int_req  = i_wake_event ||
                       (st_reg.ewc[`WSC_EWC_GLOBAL_BIT] && i_status_event);
    // Pin wake request only from enabled, non-measurement inputs
    st_next.wake_req = |(wake_level & en_eff);
  end

  ////////////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      st_reg          <= '0;
      st_reg.ewc      <= `WSC_EWC_RST;
    end else begin
      st_reg          <= st_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Pin front end: sync and pull drive
  wsc_wake_pins u_pins (
    .i_mclk      (i_mclk),
    .i_reset_n   (i_reset_n),
    .i_pin       (i_wake_pin),
    .i_pull_cfg  (st_reg.pull[5:0]),
    .o_level     (wake_level),
    .o_pull_up   (o_pull_up),
    .o_pull_down (o_pull_down)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs from the state registers; measurement active is also gated by i_mode
  assign o_rdata                     = st_reg.rdata;
  assign o_rvalid                    = st_reg.rvalid;
  assign o_int_req                   = st_reg.int_req;
  assign o_wake_req                  = st_reg.wake_req;
  assign o_wake_level                = wake_level;
  assign o_supply_peak_threshold_sel = st_reg.bc2[`WSC_BC2_PEAK_BIT];
  assign o_second_timer_wake_en      = st_reg.iwc[`WSC_IWC_T2_BIT];
  assign o_first_timer_wake_en       = st_reg.iwc[`WSC_IWC_T1_BIT];
  assign o_stop_watchdog_off_bit1    = st_reg.iwc[`WSC_IWC_WD_BIT];
  assign o_int_global                = st_reg.ewc[`WSC_EWC_GLOBAL_BIT];
  assign o_wake_measure_sel          = st_reg.ewc[`WSC_EWC_MEAS_BIT];
  // Measurement only runs in normal mode; host must ignore levels one and two then
  assign o_wake_measure_active       = st_reg.ewc[`WSC_EWC_MEAS_BIT] &&
                                       (i_mode == WSC_MODE_NORMAL);
  assign o_wake_in_en                = en_eff;

  ////////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_reset_n);

  // Plain cycle: no reset, restart or fail-safe step
  // overrides what a host write stores
  logic       quiet;   // Plain cycle
  logic [7:0] rd_mask; // Implemented bits at the address

  assign quiet = !i_soft_reset && !i_restart && !i_failsafe_entry;

  // Implemented-bit mask per address; unmapped has none
  always_comb begin
    case (i_addr)
      `WSC_OFF_BUS_CTRL2: begin
        rd_mask = `WSC_BC2_MASK;
      end
      `WSC_OFF_INT_WAKE: begin
        rd_mask = `WSC_IWC_MASK;
      end
      `WSC_OFF_EXT_WAKE: begin
        rd_mask = `WSC_EWC_MASK;
      end
      `WSC_OFF_PULL_CFG: begin
        rd_mask = `WSC_PULL_MASK;
      end
      default: begin
        rd_mask = 8'h00;
      end
    endcase
  end

  // Stop-mode write is dropped
  peak_stop_hold_a: assert property ((i_wr_stb && i_addr == `WSC_OFF_BUS_CTRL2 &&
      i_mode == WSC_MODE_STOP && quiet) |=>
      $stable(st_reg.bc2))
    else $error("peak bit changed by a stop-mode write");

  // Normal-mode write lands
  peak_write_a: assert property ((i_wr_stb && i_addr == `WSC_OFF_BUS_CTRL2 &&
      i_mode == WSC_MODE_NORMAL && quiet) |=>
      (o_supply_peak_threshold_sel == $past(i_wdata[`WSC_BC2_PEAK_BIT])))
    else $error("peak bit did not take the written value");

  // Init-mode write lands
  peak_init_a: assert property ((i_wr_stb && i_addr == `WSC_OFF_BUS_CTRL2 &&
      i_mode == WSC_MODE_INIT && quiet) |=>
      (o_supply_peak_threshold_sel == $past(i_wdata[`WSC_BC2_PEAK_BIT])))
    else $error("peak bit not writable in init mode");

  // Stop-mode write to any address, no interrupt
  stop_no_int_a: assert property ((i_wr_stb && i_mode == WSC_MODE_STOP &&
      !i_wake_event && !i_status_event) |=>
      !o_int_req)
    else $error("interrupt raised by an ignored write");

  // Reads answer, reserved zero
  reserved_zero_a: assert property (i_rd_stb |=>
      o_rvalid &&
      ((o_rdata & ~$past(rd_mask)) == 8'h00))
    else $error("reserved read bits not zero");

  // Reserved bits never stored
  res_store_a: assert property (((st_reg.bc2 & ~`WSC_BC2_MASK) == 8'h00) &&
      ((st_reg.iwc & ~`WSC_IWC_MASK) == 8'h00) &&
      ((st_reg.ewc & ~`WSC_EWC_MASK) == 8'h00) &&
      ((st_reg.pull & ~`WSC_PULL_MASK) == 8'h00))
    else $error("reserved bit stored");

  // Fail-safe forcing
  failsafe_a: assert property ((i_failsafe_entry && !i_soft_reset) |=>
      (st_reg.bc2 == 8'h00) && (st_reg.ewc[2:0] == 3'h7) && !st_reg.ewc[6] &&
      (st_reg.ewc[`WSC_EWC_GLOBAL_BIT] == $past(st_reg.ewc[`WSC_EWC_GLOBAL_BIT])))
    else $error("fail-safe values not forced");

  // Restart keep masks
  restart_keep_a: assert property ((i_restart && !i_soft_reset && !i_failsafe_entry &&
      !i_wr_stb && !i_wd_off1_hw_stb) |=>
      (st_reg.bc2 == ($past(st_reg.bc2) & `WSC_BC2_KEEP)) &&
      (st_reg.iwc == ($past(st_reg.iwc) & `WSC_IWC_KEEP)) &&
      (st_reg.pull == $past(st_reg.pull)))
    else $error("restart kept or cleared the wrong bits");

  // Restart, external wake
  restart_ewc_a: assert property ((i_restart && !i_soft_reset && !i_failsafe_entry &&
      !i_wr_stb) |=>
      (st_reg.ewc == ($past(st_reg.ewc) & `WSC_EWC_KEEP)))
    else $error("restart changed external wake bits");

  // Soft reset values
  soft_reset_a: assert property (i_soft_reset |=>
      (st_reg.ewc == 8'h07) &&
      (st_reg.iwc == 8'h00) && (st_reg.bc2 == 8'h00) && (st_reg.pull == 8'h00))
    else $error("soft reset values wrong");

  // Measuring mutes enables
  meas_ignore_a: assert property (o_wake_measure_sel |-> (o_wake_in_en[1:0] == 2'h0))
    else $error("wake inputs one/two enabled while measuring");

  // Measuring pins never wake
  meas_wake_a: assert property ((o_wake_measure_sel && !o_wake_in_en[2]) |=>
      !o_wake_req)
    else $error("pin wake from a measuring input");

  // Input three enable write
  wake_en_a: assert property ((i_wr_stb && i_addr == `WSC_OFF_EXT_WAKE && quiet) |=>
      (o_wake_in_en[2] == $past(i_wdata[2])))
    else $error("wake input three enable not taken");

  // Timer enables write
  timer_write_a: assert property ((i_wr_stb && i_addr == `WSC_OFF_INT_WAKE && quiet) |=>
      ({o_second_timer_wake_en, o_first_timer_wake_en} == $past(i_wdata[7:6])))
    else $error("timer wake enables not written");

  // Pull fields write
  pull_write_a: assert property ((i_wr_stb && i_addr == `WSC_OFF_PULL_CFG && quiet) |=>
      (st_reg.pull == ($past(i_wdata) & `WSC_PULL_MASK)))
    else $error("pull fields not written");

  // Status outside global mode
  int_scope_a: assert property ((i_status_event && !i_wake_event && !o_int_global) |=>
      !o_int_req)
    else $error("status event raised interrupt outside global mode");

  // Wake always interrupts
  int_wake_a: assert property (i_wake_event |=>
      o_int_req)
    else $error("wake event raised no interrupt");

  // Global mode passes status
  int_global_a: assert property ((i_status_event && o_int_global) |=>
      o_int_req)
    else $error("status event lost in global mode");

  // Device watchdog update
  wd_update_a: assert property ((i_wd_off1_hw_stb && !i_soft_reset && !i_restart) |=>
      (o_stop_watchdog_off_bit1 == $past(i_wd_off1_hw_val)))
    else $error("device update of watchdog bit lost");

  // Main scenarios
  cover_failsafe_c: cover property (i_failsafe_entry ##1
      o_wake_in_en == 3'h7);
  cover_stop_write_c: cover property (i_wr_stb && i_addr == `WSC_OFF_BUS_CTRL2 &&
      i_mode == WSC_MODE_STOP);
  cover_meas_c: cover property (o_wake_measure_active);
  cover_restart_c: cover property (i_restart && o_first_timer_wake_en);
  cover_global_c: cover property (i_status_event && o_int_global ##1
      o_int_req);

endmodule

/* File: bench/wsc_host_model.sv */
// Host model: issues register reads and writes into the wake source bank
module wsc_host_model (
  // Clock
  input  wire logic       i_mclk,
  // Access strobes toward the bank
  output logic            o_wr_stb,
  output logic            o_rd_stb,
  output logic [6:0]      o_addr,
  output logic [7:0]      o_wdata,
  // Read answer
  input  wire logic [7:0] i_rdata,
  input  wire logic       i_rvalid
);
  timeunit 1ns;
  timeprecision 100ps;

  ////////////////////////////////////////////////////////////////////////////////
  // Idle bus at time zero
  initial begin
    o_wr_stb = 1'b0;
    o_rd_stb = 1'b0;
    o_addr   = 7'h7f;
    o_wdata  = 8'h00;
  end

  // One write, taken at the first edge after the request
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(posedge i_mclk);
    #1;
    o_addr   = a;
    o_wdata  = d;
    o_wr_stb = 1'b1;
    @(posedge i_mclk);
    #1;
    o_wr_stb = 1'b0;
    // Released lines must not keep the last value
    o_addr   = ~a;
    o_wdata  = ~d;
  endtask

  // One read; the answer strobe stands for the cycle after the taking edge
  task automatic rd(input logic [6:0] a, output logic [7:0] d);
    @(posedge i_mclk);
    #1;
    o_addr   = a;
    o_rd_stb = 1'b1;
    @(posedge i_mclk);
    #1;
    o_rd_stb = 1'b0;
    o_addr   = ~a;
    // A missing strobe yields unknown data, so the compare fails
    d        = (i_rvalid === 1'b1) ? i_rdata : 8'hxx;
  endtask
endmodule

/* File: bench/wsc_regs_test.sv */
// Self-checking bench for the wake source control register bank
`include "wsc_consts.svh"
module wsc_regs_test;
  timeunit 1ns;
  timeprecision 100ps;
  import wsc_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  // Register addresses, one unmapped
  localparam logic [6:0] A_BC2  = `WSC_OFF_BUS_CTRL2;
  localparam logic [6:0] A_IWC  = `WSC_OFF_INT_WAKE;
  localparam logic [6:0] A_EWC  = `WSC_OFF_EXT_WAKE;
  localparam logic [6:0] A_PULL = `WSC_OFF_PULL_CFG;
  localparam logic [6:0] A_NONE = 7'h09;

  // Stimulus and observed signals
  logic       i_mclk, i_reset_n, wr_stb, rd_stb, rvalid;
  logic [6:0] addr;
  logic [7:0] wdata, rdata;
  wsc_mode_e  mode;
  logic       soft_rst, restart, fs_entry, wd_stb, wd_val, wake_ev, stat_ev;
  logic [2:0] pin, level, pu, pd, in_en;
  logic       int_req, wake_req, peak, t1, t2, wdoff, glob, meas, meas_act;
  int         n_fail, total_checks;

  ////////////////////////////////////////////////////////////////////////////////
  // Design and host
  wsc_regs dut (
    .i_mclk(i_mclk), .i_reset_n(i_reset_n), .i_wr_stb(wr_stb), .i_rd_stb(rd_stb),
    .i_addr(addr), .i_wdata(wdata), .o_rdata(rdata), .o_rvalid(rvalid),
    .i_mode(mode), .i_soft_reset(soft_rst), .i_restart(restart),
    .i_failsafe_entry(fs_entry), .i_wd_off1_hw_stb(wd_stb), .i_wd_off1_hw_val(wd_val),
    .i_wake_event(wake_ev), .i_status_event(stat_ev), .o_int_req(int_req),
    .i_wake_pin(pin), .o_wake_level(level), .o_pull_up(pu), .o_pull_down(pd),
    .o_wake_req(wake_req), .o_supply_peak_threshold_sel(peak),
    .o_first_timer_wake_en(t1), .o_second_timer_wake_en(t2),
    .o_stop_watchdog_off_bit1(wdoff), .o_int_global(glob), .o_wake_measure_sel(meas),
    .o_wake_measure_active(meas_act), .o_wake_in_en(in_en));

  wsc_host_model host (
    .i_mclk(i_mclk), .o_wr_stb(wr_stb), .o_rd_stb(rd_stb), .o_addr(addr),
    .o_wdata(wdata), .i_rdata(rdata), .i_rvalid(rvalid));

  ////////////////////////////////////////////////////////////////////////////////
  // Clock, 25 ns period
  initial begin
    i_mclk = 1'b0;
    forever #12.5 i_mclk = ~i_mclk;
  end

  // Hang guard: a run this long counts as a mismatch
  initial begin
    repeat (20000) @(posedge i_mclk);
    n_fail++;
    tally_and_finish;
  end

  // Step to just after the next rising edge
  task automatic cyc;
    @(posedge i_mclk);
    #1;
  endtask

  // Compare and count
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Read a register and compare
  task automatic rchk(input logic [6:0] a, input logic [7:0] exp);
    logic [7:0] d;
    host.rd(a, d);
    chk(d, exp);
  endtask

  // Same value into all four registers
  task automatic fill(input logic [7:0] d);
    host.wr(A_BC2, d);
    host.wr(A_IWC, d);
    host.wr(A_EWC, d);
    host.wr(A_PULL, d);
  endtask

  // Power-on values of the bank
  task automatic rst_vals;
    rchk(A_BC2, 8'h00);
    rchk(A_IWC, 8'h00);
    rchk(A_EWC, 8'h07);
    rchk(A_PULL, 8'h00);
  endtask

  // One event cycle, then the interrupt request a cycle later
  task automatic ev(input logic w, input logic s, input logic exp);
    cyc;
    wake_ev = w;
    stat_ev = s;
    cyc;
    chk({7'h00, int_req}, {7'h00, exp});
    wake_ev = 1'b0;
    stat_ev = 1'b0;
  endtask

  // Verdict and end of run
  task automatic tally_and_finish;
    if (n_fail == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    {soft_rst, restart, fs_entry, wd_stb, wd_val, wake_ev, stat_ev} = 7'h00;
    n_fail       = 0;
    total_checks = 0;
    mode         = WSC_MODE_INIT;
    pin          = 3'h0;
    i_reset_n    = 1'b0;
    repeat (2) @(posedge i_mclk);
    #1;
    chk({5'h00, in_en}, 8'h07);
    i_reset_n = 1'b1;
    rst_vals;
    // All-ones in normal mode land on implemented bits only
    mode = WSC_MODE_NORMAL;
    fill(8'hff);
    rchk(A_BC2, 8'h20);
    rchk(A_IWC, 8'hc4);
    rchk(A_EWC, 8'ha7);
    rchk(A_PULL, 8'h3f);
    rchk(A_NONE, 8'h00);
    chk({peak, t2, t1, wdoff, glob, meas, meas_act, 1'b0}, 8'hfe);
    chk({5'h00, in_en}, 8'h04);
    // Stop and other modes: peak bit holds, no interrupt even with global scope; init-mode write lands
    mode = WSC_MODE_STOP;
    host.wr(A_BC2, 8'h00);
    chk({6'h00, int_req, meas_act}, 8'h00);
    rchk(A_BC2, 8'h20);
    mode = WSC_MODE_OTHER;
    host.wr(A_BC2, 8'h00);
    rchk(A_BC2, 8'h20);
    mode = WSC_MODE_INIT;
    host.wr(A_BC2, 8'h00);
    rchk(A_BC2, 8'h00);
    // Restart keeps only the documented bits
    mode = WSC_MODE_NORMAL;
    fill(8'hff);
    cyc;
    restart = 1'b1;
    cyc;
    restart = 1'b0;
    rchk(A_BC2, 8'h20);
    rchk(A_IWC, 8'hc0);
    rchk(A_EWC, 8'ha7);
    rchk(A_PULL, 8'h3f);
    // Fail-safe clears the peak bit and forces the wake enables on, internal wake untouched
    host.wr(A_EWC, 8'h80);
    cyc;
    fs_entry = 1'b1;
    cyc;
    fs_entry = 1'b0;
    rchk(A_BC2, 8'h00);
    rchk(A_EWC, 8'h87);
    rchk(A_IWC, 8'hc0);
    // Soft reset reloads power-on values
    cyc;
    soft_rst = 1'b1;
    cyc;
    soft_rst = 1'b0;
    rst_vals;
    // Device-side update of the watchdog stop-off bit
    cyc;
    wd_stb = 1'b1;
    wd_val = 1'b1;
    cyc;
    wd_stb = 1'b0;
    chk({7'h00, wdoff}, 8'h01);
    rchk(A_IWC, 8'h04);
    // Interrupt scope: wake only, then every status bit
    ev(1'b0, 1'b1, 1'b0);
    ev(1'b1, 1'b0, 1'b1);
    host.wr(A_EWC, 8'h87);
    ev(1'b0, 1'b1, 1'b1);
    // Pull codes and pin wake
    host.wr(A_PULL, 8'h24);
    pin = 3'h1;
    repeat (7) cyc;
    chk({wake_req, level, 4'h0}, 8'h90);
    chk({2'h0, pu, pd}, 8'h22);
    host.wr(A_PULL, 8'h03);
    repeat (3) cyc;
    chk({2'h0, pu, pd}, 8'h08);
    // Measurement mutes inputs one and two; their levels are not looked at
    host.wr(A_EWC, 8'ha3);
    pin = 3'h3;
    repeat (7) cyc;
    chk({7'h00, wake_req}, 8'h00);
    // Only input three enabled
    host.wr(A_EWC, 8'h84);
    repeat (3) cyc;
    chk({7'h00, wake_req}, 8'h00);
    pin = 3'h4;
    repeat (7) cyc;
    chk({7'h00, wake_req}, 8'h01);
    tally_and_finish;
  end
endmodule
